// ==== hw/scmc_defs.vh ====
// Constants shared by the system clock mode control block.
//
// Notes on behaviour
// RULE1: Wait-mode gate bit set stops the peripheral clock during wait mode.
// RULE2: Crystal stop halts oscillation only in on-chip modes; external clock still passes.
// RULE3: Divide-by-8 bit overrides; else field gives none, /2, /4, /16.
// RULE4: Entering stop mode forces the divide-by-8 bit to one.
// RULE5: All-clock-stop enters stop mode; feedback resistor off by bit or stop.
// RULE6: Crystal pin select, once written one, ignores zero until reset.
// RULE7: Low-speed oscillator off allowed only with crystal system clock, else held zero.
// RULE8: Wait bit stops CPU clock; oscillators keep running, peripherals too unless the wait-mode gate bit is set.
// RULE9: Interrupt ends wait mode and clears the wait bit.
// RULE10: Wake no-division bit at wait entry clears divide-by-8 and field.
// RULE11: Wake clock field picks clock after wait or stop; 00 keeps previous.
// RULE12: Wake code 10 selects on-chip, enables and selects high-speed oscillator.
// RULE13: Wake code 11 clears crystal stop, sets pin select, selects crystal.
// RULE14: Crystal-stopped flag is valid only with detection enabled, else zero.
// RULE15: Detected crystal stop with both enables set forces on-chip clock.
// RULE16: While crystal-stopped flag is one, writing zero to clock select ignored.
// RULE17: Software clears detection bits before stop or on-chip mode.
// RULE18: High-speed enable turns oscillator on; on-chip select picks low or high.
// RULE19: Software changes on-chip select only with both oscillators running.
// RULE20: Divide-by-128 clock source is low-speed at zero, high-speed at one.
// RULE21: Clock registers accept writes only while the unlock bit is one.
// RULE22: Read-only byte holds factory 32 MHz correction data.
// RULE23: Crystal oscillator is stopped during and after reset until enabled.
// RULE24: Source and divider changes never shorten a CPU clock period.
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SCMC_IDX_CTRL_A     8'h06
`define SCMC_IDX_CTRL_B     8'h07
`define SCMC_IDX_LPM        8'h09
`define SCMC_IDX_UNLOCK     8'h0A
`define SCMC_IDX_STOPDET    8'h0C
`define SCMC_IDX_TRIM32     8'h15
`define SCMC_IDX_HSCTRL     8'h23
`define SCMC_IDX_FTRIM      8'h24

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define SCMC_RST_CTRL_A     8'h28
`define SCMC_RST_CTRL_B     8'h20
`define SCMC_RST_LPM        8'h00
`define SCMC_RST_STOPDET    8'h04
`define SCMC_RST_HSCTRL     8'h00
`define SCMC_MSK_LPM        8'hF9
`define SCMC_MSK_STOPDET    8'hF7
`define SCMC_MSK_HSCTRL     8'h0F
`define SCMC_RST_TRIM       8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCMC_A_PGATE        2
`define SCMC_A_XSTOP        5
`define SCMC_A_DIV8         6
`define SCMC_B_ACS          0
`define SCMC_B_FBOFF        1
`define SCMC_B_PIN          3
`define SCMC_B_LSOFF        4
`define SCMC_B_DIVLO        6
`define SCMC_B_DIVHI        7
`define SCMC_C_WAIT         0
`define SCMC_C_NODIV        5
`define SCMC_C_WAKELO       6
`define SCMC_C_WAKEHI       7
`define SCMC_D_EN           0
`define SCMC_D_IRQ          1
`define SCMC_D_SYS          2
`define SCMC_D_FLAG         3
`define SCMC_F_HSEN         0
`define SCMC_F_OSEL         1
`define SCMC_F_S128         3
`define SCMC_U_UNLOCK       0

// ----------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------
`define SCMC_WAKE_HSO       2'b10
`define SCMC_WAKE_XTAL      2'b11
`define SCMC_DIV_NONE       2'b00
`define SCMC_DIV_2          2'b01
`define SCMC_DIV_4          2'b10
`define SCMC_RAT_1          4'h0
`define SCMC_RAT_2          4'h1
`define SCMC_RAT_4          4'h3
`define SCMC_RAT_8          4'h7
`define SCMC_RAT_16         4'hF
`define SCMC_RAT_128        7'h7F
`define SCMC_SRC_XTAL       2'b00
`define SCMC_SRC_LSO        2'b01
`define SCMC_SRC_HSO        2'b10
`define SCMC_SWITCH_TMO     1024
`define SCMC_TMO_W          11

`endif

// ==== hw/scmc_tick_div.v ====
// Tick divider whose ratio is taken up only at the end of a period.
`timescale 1ns/1ps
module scmc_tick_div #(
   parameter CW = 4
) (
   // Clock and reset.
   input  wire          hclk,
   input  wire          hresetn,
   input  wire          ce,
   // Ticks in, ratio (count minus one) and ticks out.
   input  wire          tick_in,
   input  wire [CW-1:0] ratio,
   output wire          tick_out
);

   reg  [CW-1:0] cnt_q;
   reg  [CW-1:0] rat_q;
   wire          wrap;

   assign wrap     = tick_in && (cnt_q >= rat_q);
   assign tick_out = wrap;

   // A new ratio waits for the current period to finish.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= {CW{1'b0}};
         rat_q <= {CW{1'b0}};
      end else if (ce && tick_in) begin
         if (wrap) begin
            cnt_q <= {CW{1'b0}};
            rat_q <= ratio; // [RULE24]
         end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // scmc_tick_div

// ==== hw/scmc_src_switch.v ====
// Glitch-free switch between three source tick streams.
`timescale 1ns/1ps
`include "scmc_defs.vh"
module scmc_src_switch #(
   parameter TMO = `SCMC_SWITCH_TMO
) (
   // Clock and reset.
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       ce,
   // Requested source and source ticks.
   input  wire [1:0] sel,
   input  wire       xtal_tick,
   input  wire       lso_tick,
   input  wire       hso_tick,
   // Selected ticks.
   output wire       tick_out
);

   reg  [1:0]            cur_q;
   reg                   skip_q;
   reg  [`SCMC_TMO_W-1:0] tmo_q;
   reg                   t_cur;
   wire                  chg;
   wire                  tmo_hit;

   always @* begin
      case (cur_q)
         `SCMC_SRC_XTAL: t_cur = xtal_tick;
         `SCMC_SRC_LSO:  t_cur = lso_tick;
         `SCMC_SRC_HSO:  t_cur = hso_tick;
         default:        t_cur = 1'b0;
      endcase
   end

   assign chg      = (sel != cur_q);
   assign tmo_hit  = (tmo_q == TMO[`SCMC_TMO_W-1:0]);
   assign tick_out = t_cur && !skip_q;

   // The switch happens on the old source's edge; the first new tick is
   // dropped so no output period is shorter than a full new period. A dead
   // old source is abandoned after a timeout.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_q  <= `SCMC_SRC_LSO;
         skip_q <= 1'b0;
         tmo_q  <= {`SCMC_TMO_W{1'b0}};
      end else if (ce) begin
         if (chg && (t_cur || tmo_hit)) begin
            cur_q  <= sel; // [RULE24]
            skip_q <= 1'b1;
            tmo_q  <= {`SCMC_TMO_W{1'b0}};
         end else begin
            if (skip_q && t_cur)
               skip_q <= 1'b0;
            if (chg)
               tmo_q <= tmo_q + {{(`SCMC_TMO_W-1){1'b0}}, 1'b1};
            else
               tmo_q <= {`SCMC_TMO_W{1'b0}};
         end
      end
   end

endmodule // scmc_src_switch

// ==== hw/scmc_top.v ====
// System clock mode control with its AHB-Lite register slave.
`timescale 1ns/1ps
`include "scmc_defs.vh"
module scmc_top #(
   parameter [7:0] TRIM32_VALUE = `SCMC_RST_TRIM,
   parameter [7:0] FTRIM_RESET  = `SCMC_RST_TRIM,
   parameter       SWITCH_TMO   = `SCMC_SWITCH_TMO
) (
   // Clock, reset and clock enable.
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire [31:0] hrdata,
   output wire        hresp,
   // Oscillator ticks, detector and wake request.
   input  wire        xtal_tick,
   input  wire        lowspeed_onchip_clk,
   input  wire        highspeed_onchip_clk,
   input  wire        xtal_stop_detect,
   input  wire        periph_irq,
   // Clock enables out.
   output wire        cpu_clk_en,
   output wire        periph_clk_en,
   output wire        onchip_div128_clk,
   // Oscillator and pin controls.
   output wire        xtal_osc_enable,
   output wire        xtal_buf_enable,
   output wire        feedback_res_en,
   output wire        xtal_pin_select,
   output wire        lsosc_enable,
   output wire        hsosc_enable,
   output wire        wait_mode,
   output wire        stop_mode
);

   // -------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------
   reg  [7:0]  a_q, a_d;
   reg  [7:0]  b_q, b_d;
   reg  [7:0]  c_q, c_d;
   reg  [7:0]  d_q, d_d;
   reg  [7:0]  f_q, f_d;
   reg  [7:0]  t_q, t_d;
   reg         u_q, u_d;
   reg         busy_q;
   reg         wr_q;
   reg         ok_q;
   reg  [7:0]  idx_q;
   reg         rdy_q;
   reg  [7:0]  rd_q;
   reg         cpu_q;
   reg         per_q;
   reg         d128_q;
   reg         xosc_q;
   reg         xbuf_q;
   reg         fb_q;
   reg         ls_q;
   reg         hs_q;
   wire        take;
   wire        wr;
   wire [7:0]  wd;
   wire        wr_lock;
   wire        wait_in;
   wire        stop_in;
   wire        wake;
   wire [1:0]  src;
   wire        src_tick;
   wire        div_tick;
   wire        d128_tick;
   wire        d128_src;
   reg  [7:0]  rd_d;

   // -------------------------------------------------------------------
   // Divider ratio from the division bits
   // -------------------------------------------------------------------
   function [3:0] div_ratio;
      input       div8;
      input [1:0] field;
      begin
         if (div8)
            div_ratio = `SCMC_RAT_8; // [RULE3]
         else
            case (field)
               `SCMC_DIV_NONE: div_ratio = `SCMC_RAT_1;
               `SCMC_DIV_2:    div_ratio = `SCMC_RAT_2;
               `SCMC_DIV_4:    div_ratio = `SCMC_RAT_4;
               default:        div_ratio = `SCMC_RAT_16;
            endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Bus slave: one wait state, then the access completes
   // -------------------------------------------------------------------
   assign take    = hsel && htrans[1] && hready;
   assign wr      = busy_q && wr_q && ok_q;
   assign wd      = hwdata[7:0];
   assign wr_lock = wr && u_q; // [RULE21]

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         wr_q   <= 1'b0;
         ok_q   <= 1'b0;
         idx_q  <= 8'h00;
         rdy_q  <= 1'b1;
         rd_q   <= 8'h00;
      end else if (ce) begin
         if (busy_q) begin
            busy_q <= 1'b0;
            rdy_q  <= 1'b1;
            rd_q   <= (!wr_q && ok_q) ? rd_d : 8'h00;
         end else if (take) begin
            busy_q <= 1'b1;
            rdy_q  <= 1'b0;
            wr_q   <= hwrite;
            ok_q   <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
            idx_q  <= haddr[9:2];
         end
      end
   end

   always @* begin
      case (idx_q)
         `SCMC_IDX_CTRL_A:  rd_d = a_q;
         `SCMC_IDX_CTRL_B:  rd_d = b_q;
         `SCMC_IDX_LPM:     rd_d = c_q;
         `SCMC_IDX_UNLOCK:  rd_d = {7'h00, u_q};
         `SCMC_IDX_STOPDET: rd_d = d_q;
         `SCMC_IDX_TRIM32:  rd_d = TRIM32_VALUE; // [RULE22]
         `SCMC_IDX_HSCTRL:  rd_d = f_q;
         `SCMC_IDX_FTRIM:   rd_d = t_q;
         default:           rd_d = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------
   // Mode entry and exit
   // -------------------------------------------------------------------
   assign wait_in = wr_lock && (idx_q == `SCMC_IDX_LPM) &&
                    wd[`SCMC_C_WAIT] && !c_q[`SCMC_C_WAIT];
   assign stop_in = wr_lock && (idx_q == `SCMC_IDX_CTRL_B) &&
                    wd[`SCMC_B_ACS] && !b_q[`SCMC_B_ACS];
   assign wake    = periph_irq && (c_q[`SCMC_C_WAIT] || b_q[`SCMC_B_ACS]);

   // -------------------------------------------------------------------
   // Next register values; hardware updates follow software writes
   // -------------------------------------------------------------------
   always @* begin
      a_d = a_q;
      b_d = b_q;
      c_d = c_q;
      d_d = d_q;
      f_d = f_q;
      t_d = t_q;
      u_d = u_q;
      if (wr && (idx_q == `SCMC_IDX_UNLOCK))
         u_d = wd[`SCMC_U_UNLOCK];
      if (wr_lock) begin
         case (idx_q)
            `SCMC_IDX_CTRL_A: a_d = wd;
            `SCMC_IDX_CTRL_B: begin
               b_d = wd;
               b_d[`SCMC_B_PIN] = b_q[`SCMC_B_PIN] | wd[`SCMC_B_PIN]; // [RULE6]
            end
            `SCMC_IDX_LPM: c_d = wd & `SCMC_MSK_LPM;
            `SCMC_IDX_STOPDET: begin
               d_d = (wd & `SCMC_MSK_STOPDET) | (d_q & ~`SCMC_MSK_STOPDET);
               if (d_q[`SCMC_D_FLAG])
                  d_d[`SCMC_D_SYS] = 1'b1; // [RULE16]
            end
            `SCMC_IDX_HSCTRL: f_d = wd & `SCMC_MSK_HSCTRL;
            `SCMC_IDX_FTRIM:  t_d = wd;
            default: ;
         endcase
      end
      if (wait_in && c_d[`SCMC_C_NODIV]) begin
         a_d[`SCMC_A_DIV8]  = 1'b0; // [RULE10]
         b_d[`SCMC_B_DIVLO] = 1'b0;
         b_d[`SCMC_B_DIVHI] = 1'b0;
      end
      if (stop_in)
         a_d[`SCMC_A_DIV8] = 1'b1; // [RULE4]
      if (wake) begin
         c_d[`SCMC_C_WAIT] = 1'b0; // [RULE9]
         b_d[`SCMC_B_ACS]  = 1'b0;
         case (c_q[`SCMC_C_WAKEHI:`SCMC_C_WAKELO]) // [RULE11]
            `SCMC_WAKE_HSO: begin
               d_d[`SCMC_D_SYS]  = 1'b1; // [RULE12]
               f_d[`SCMC_F_HSEN] = 1'b1;
               f_d[`SCMC_F_OSEL] = 1'b1;
            end
            `SCMC_WAKE_XTAL: begin
               a_d[`SCMC_A_XSTOP] = 1'b0; // [RULE13]
               b_d[`SCMC_B_PIN]   = 1'b1;
               d_d[`SCMC_D_SYS]   = 1'b0;
            end
            default: ;
         endcase
      end
      if (xtal_stop_detect && d_q[`SCMC_D_EN] && d_q[`SCMC_D_IRQ])
         d_d[`SCMC_D_SYS] = 1'b1; // [RULE15]
      if (d_d[`SCMC_D_SYS])
         b_d[`SCMC_B_LSOFF] = 1'b0; // [RULE7]
      d_d[`SCMC_D_FLAG] = d_d[`SCMC_D_EN] && xtal_stop_detect; // [RULE14]
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_q <= `SCMC_RST_CTRL_A; // [RULE23]
         b_q <= `SCMC_RST_CTRL_B;
         c_q <= `SCMC_RST_LPM;
         d_q <= `SCMC_RST_STOPDET;
         f_q <= `SCMC_RST_HSCTRL;
         t_q <= FTRIM_RESET;
         u_q <= 1'b0;
      end else if (ce) begin
         a_q <= a_d;
         b_q <= b_d;
         c_q <= c_d;
         d_q <= d_d;
         f_q <= f_d;
         t_q <= t_d;
         u_q <= u_d;
      end
   end

   // -------------------------------------------------------------------
   // Clock path
   // -------------------------------------------------------------------
   assign src = !d_q[`SCMC_D_SYS] ? `SCMC_SRC_XTAL :
                (f_q[`SCMC_F_OSEL] ? `SCMC_SRC_HSO : `SCMC_SRC_LSO); // [RULE18]
   assign d128_src = f_q[`SCMC_F_S128] ? highspeed_onchip_clk
                                       : lowspeed_onchip_clk; // [RULE20]

   scmc_src_switch #(
      .TMO (SWITCH_TMO)
   ) u_switch (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .sel       (src),
      .xtal_tick (xtal_tick),
      .lso_tick  (lowspeed_onchip_clk),
      .hso_tick  (highspeed_onchip_clk),
      .tick_out  (src_tick)
   );

   scmc_tick_div #(
      .CW (4)
   ) u_cpu_div (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .tick_in  (src_tick),
      .ratio    (div_ratio(a_q[`SCMC_A_DIV8],
                           b_q[`SCMC_B_DIVHI:`SCMC_B_DIVLO])),
      .tick_out (div_tick)
   );

   scmc_tick_div #(
      .CW (7)
   ) u_div128 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .tick_in  (d128_src),
      .ratio    (`SCMC_RAT_128),
      .tick_out (d128_tick)
   );

   // -------------------------------------------------------------------
   // Registered outputs
   // -------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_q  <= 1'b0;
         per_q  <= 1'b0;
         d128_q <= 1'b0;
         xosc_q <= 1'b0;
         xbuf_q <= 1'b0;
         fb_q   <= 1'b0;
         ls_q   <= 1'b1;
         hs_q   <= 1'b0;
      end else if (ce) begin
         cpu_q  <= div_tick && !c_q[`SCMC_C_WAIT] &&
                   !b_q[`SCMC_B_ACS]; // [RULE8]
         per_q  <= src_tick && !b_q[`SCMC_B_ACS] &&
                   !(c_q[`SCMC_C_WAIT] && a_q[`SCMC_A_PGATE]); // [RULE1]
         d128_q <= d128_tick && !b_q[`SCMC_B_ACS];
         xosc_q <= b_q[`SCMC_B_PIN] && !b_q[`SCMC_B_ACS] &&
                   !(a_q[`SCMC_A_XSTOP] && d_q[`SCMC_D_SYS]); // [RULE2]
         xbuf_q <= b_q[`SCMC_B_PIN] && !b_q[`SCMC_B_ACS] &&
                   !a_q[`SCMC_A_XSTOP];
         fb_q   <= !b_q[`SCMC_B_FBOFF] && !b_q[`SCMC_B_ACS]; // [RULE5]
         ls_q   <= !b_q[`SCMC_B_LSOFF] && !b_q[`SCMC_B_ACS];
         hs_q   <= f_q[`SCMC_F_HSEN] && !b_q[`SCMC_B_ACS]; // [RULE18]
      end
   end

   assign hreadyout         = rdy_q;
   assign hrdata            = {24'h000000, rd_q};
   assign hresp             = 1'b0;
   assign cpu_clk_en        = cpu_q;
   assign periph_clk_en     = per_q;
   assign onchip_div128_clk = d128_q;
   assign xtal_osc_enable   = xosc_q;
   assign xtal_buf_enable   = xbuf_q;
   assign feedback_res_en   = fb_q;
   assign xtal_pin_select   = b_q[`SCMC_B_PIN];
   assign lsosc_enable      = ls_q;
   assign hsosc_enable      = hs_q;
   assign wait_mode         = c_q[`SCMC_C_WAIT];
   assign stop_mode         = b_q[`SCMC_B_ACS];

endmodule // scmc_top

// ==== dv/scmc_top_asserts.sv ====
// Concurrent checks on the ports of the clock mode control block.
`timescale 1ns/1ps
module scmc_checker (
   // Clock and reset.
   input wire        hclk,
   input wire        hresetn,
   input wire        ce,
   // Register bus.
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hready,
   input wire        hreadyout,
   input wire [31:0] hrdata,
   input wire        hresp,
   // Wake request and clock outputs.
   input wire        periph_irq,
   input wire        cpu_clk_en,
   input wire        periph_clk_en,
   input wire        onchip_div128_clk,
   input wire        xtal_osc_enable,
   input wire        feedback_res_en,
   input wire        xtal_pin_select,
   input wire        hsosc_enable,
   input wire        wait_mode,
   input wire        stop_mode
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Cycles since the last divided pulse, saturating at 127.
   reg  [6:0] gap_q;
   wire [6:0] gap_d = onchip_div128_clk ? 7'h00 :
                      (gap_q == 7'h7F) ? gap_q : gap_q + 7'h01;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) gap_q <= 7'h7F;
      else gap_q <= gap_d;
   end

   property p_ready;
      hsel && htrans[1] && hready && ce |=> !hreadyout ##1 hreadyout;
   endproperty
   property p_okay;
      hresp == 1'b0 && hrdata[31:8] == 24'h0;
   endproperty
   property p_pin;
      xtal_pin_select |=> xtal_pin_select;
   endproperty
   property p_osc;
      xtal_osc_enable |-> xtal_pin_select;
   endproperty
   property p_stop;
      (ce && stop_mode)[*3] |-> !cpu_clk_en && !periph_clk_en &&
         !feedback_res_en && !xtal_osc_enable && !hsosc_enable;
   endproperty
   property p_wait;
      (ce && wait_mode)[*3] |-> !cpu_clk_en;
   endproperty
   property p_wake;
      ce && periph_irq && (wait_mode || stop_mode) |=>
         !wait_mode && !stop_mode;
   endproperty
   property p_d128;
      onchip_div128_clk |-> gap_q == 7'h7F;
   endproperty

   a_ready: assert property (p_ready) else $error("data phase timing");
   a_okay: assert property (p_okay) else $error("response or data high");
   a_pin: assert property (p_pin) else $error("pin select fell");
   a_osc: assert property (p_osc) else $error("osc without pin");
   a_stop: assert property (p_stop) else $error("clock in stop");
   a_wait: assert property (p_wait) else $error("cpu tick in wait");
   a_wake: assert property (p_wake) else $error("no wake exit");
   a_d128: assert property (p_d128) else $error("div128 gap");

   c_wake: cover property (wait_mode ##1 !wait_mode);
   c_stop: cover property (stop_mode ##1 !stop_mode);
   c_d128: cover property (onchip_div128_clk);
endmodule // scmc_checker

bind scmc_top scmc_checker chk_u (.*);

// ==== dv/testbench.sv ====
// Self-checking bench for the clock mode control block.
`timescale 1ns/1ps
`include "scmc_defs.vh"
`define CHK(got, exp) begin compares = compares + 1; \
   if ((got) !== (exp)) begin errors = errors + 1; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module testbench;
   // ------------------------------------------------------------------
   // Stimulus, design and scenarios
   // ------------------------------------------------------------------
   localparam [7:0] TRIM_V  = 8'h5A; // Arbitrary test value.
   localparam [7:0] FTRIM_V = 8'hA5; // Arbitrary test value.
   localparam [7:0] IX_A = `SCMC_IDX_CTRL_A;
   localparam [7:0] IX_B = `SCMC_IDX_CTRL_B;
   localparam [7:0] IX_C = `SCMC_IDX_LPM;
   localparam [7:0] IX_D = `SCMC_IDX_STOPDET;
   localparam [7:0] IX_H = `SCMC_IDX_HSCTRL;
   reg         hclk, hresetn, hsel, hwrite, xtal_tick, periph_irq;
   reg         lowspeed_onchip_clk, highspeed_onchip_clk, xtal_stop_detect;
   reg  [1:0]  htrans;
   reg  [31:0] haddr, hwdata;
   reg  [7:0]  rd, tk_q = 8'h00;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, cpu_clk_en, periph_clk_en, onchip_div128_clk;
   wire        xtal_osc_enable, xtal_buf_enable, feedback_res_en;
   wire        xtal_pin_select, lsosc_enable, hsosc_enable;
   wire        wait_mode, stop_mode;
   integer     errors, compares, g, i;

   scmc_top #(.TRIM32_VALUE(TRIM_V), .FTRIM_RESET(FTRIM_V), .SWITCH_TMO(16))
   dut_u (.*, .ce(1'b1), .hsize(3'h2), .hready(hreadyout));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Crystal and slow source tick every 4 cycles, fast source every 2.
   always @(posedge hclk) begin
      tk_q <= tk_q + 8'h01;
      xtal_tick <= tk_q[1:0] == 2'h0;
      lowspeed_onchip_clk <= tk_q[1:0] == 2'h1;
      highspeed_onchip_clk <= tk_q[0];
   end

   task end_of_test;
      begin
         if (errors == 0 && compares > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask

   task bail;
      begin
         errors = errors + 1;
         end_of_test;
      end
   endtask

   task wait_rdy;
      integer n;
      begin
         n = 0;
         while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            n = n + 1;
            if (n > 20) bail;
         end
      end
   endtask

   task xfer(input [7:0] idx, input w, input [7:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {22'h0, idx, 2'b00};
         hwrite <= w;
         htrans <= 2'b10;
         @(posedge hclk);
         wait_rdy;
         htrans <= 2'b00;
         hwdata <= {24'h0, d};
         @(posedge hclk);
         wait_rdy;
         rd = hrdata[7:0];
      end
   endtask

   task wr(input [7:0] idx, input [7:0] d);
      xfer(idx, 1'b1, d);
   endtask

   task rdc(input [7:0] idx, input [7:0] e);
      begin
         xfer(idx, 1'b0, 8'h00);
         `CHK(rd, e)
      end
   endtask

   function sig(input integer w);
      sig = w == 0 ? cpu_clk_en : w == 1 ? periph_clk_en : onchip_div128_clk;
   endfunction

   // Gap before the fourth pulse, so that a new ratio has settled.
   task gap_of(input integer w, output integer c);
      integer n;
      for (n = 0; n < 4; n = n + 1) begin
         c = 0;
         do begin
            @(posedge hclk);
            c = c + 1;
            if (c > 600) bail;
         end while (sig(w) !== 1'b1);
      end
   endtask

   task quiet(input integer w, output integer c);
      begin
         c = 0;
         repeat (40) begin
            @(posedge hclk);
            if (sig(w) === 1'b1) c = c + 1;
         end
      end
   endtask

   task wake;
      integer n;
      begin
         periph_irq <= 1'b1;
         n = 0;
         while ((wait_mode | stop_mode) !== 1'b0) begin
            @(posedge hclk);
            n = n + 1;
            if (n > 20) bail;
         end
         periph_irq <= 1'b0;
         @(posedge hclk);
      end
   endtask

   task t_regs;
      begin
         rdc(IX_A, 8'h28);
         rdc(IX_B, 8'h20);
         rdc(IX_C, 8'h00);
         rdc(IX_D, 8'h04);
         rdc(IX_H, 8'h00);
         rdc(`SCMC_IDX_FTRIM, FTRIM_V);
         `CHK(xtal_osc_enable, 1'b0)
         `CHK(lsosc_enable, 1'b1)
         wr(IX_A, 8'h68);
         rdc(IX_A, 8'h28);
         wr(`SCMC_IDX_UNLOCK, 8'h01);
         wr(`SCMC_IDX_TRIM32, 8'h00);
         rdc(`SCMC_IDX_TRIM32, TRIM_V);
         wr(8'h3F, 8'hFF);
         rdc(8'h3F, 8'h00);
         wr(IX_B, 8'h30);
         rdc(IX_B, 8'h20);
         wr(`SCMC_IDX_FTRIM, 8'h33);
         rdc(`SCMC_IDX_FTRIM, 8'h33);
      end
   endtask

   task t_div;
      integer e;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            wr(IX_A, i == 4 ? 8'h68 : 8'h28);
            wr(IX_B, {i == 4 ? 2'b11 : i[1:0], 6'h20});
            e = i == 3 ? 64 : i == 4 ? 32 : 4 << i;
            gap_of(0, g);
            `CHK(g, e)
         end
         wr(IX_A, 8'h28);
         wr(IX_B, 8'h20);
      end
   endtask

   task t_osc;
      begin
         gap_of(2, g);
         `CHK(g, 512)
         wr(IX_H, 8'h01);
         wr(IX_H, 8'h03);
         gap_of(0, g);
         `CHK(g, 2)
         `CHK(hsosc_enable, 1'b1)
         wr(IX_H, 8'h0B);
         gap_of(2, g);
         `CHK(g, 256)
         wr(IX_H, 8'h01);
         wr(IX_H, 8'h00);
      end
   endtask

   task t_wait;
      begin
         wr(IX_B, 8'hE0);
         wr(IX_C, 8'h21);
         quiet(0, g);
         `CHK(g, 0)
         `CHK(wait_mode, 1'b1)
         gap_of(1, g);
         `CHK(g, 4)
         wake;
         rdc(IX_C, 8'h20);
         rdc(IX_B, 8'h20);
         rdc(IX_H, 8'h00);
         wr(IX_A, 8'h2C);
         wr(IX_C, 8'h81);
         quiet(1, g);
         `CHK(g, 0)
         wake;
         rdc(IX_H, 8'h03);
         rdc(IX_D, 8'h04);
         rdc(IX_C, 8'h80);
         wr(IX_H, 8'h01);
         wr(IX_H, 8'h00);
         wr(IX_A, 8'h28);
      end
   endtask

   task t_stop;
      begin
         wr(IX_C, 8'hC0);
         wr(IX_B, 8'h21);
         quiet(0, g);
         `CHK(g, 0)
         `CHK(stop_mode, 1'b1)
         `CHK(feedback_res_en, 1'b0)
         wake;
         rdc(IX_A, 8'h48);
         rdc(IX_B, 8'h28);
         rdc(IX_D, 8'h00);
         `CHK(xtal_osc_enable, 1'b1)
         `CHK(xtal_buf_enable, 1'b1)
         wr(IX_B, 8'h20);
         rdc(IX_B, 8'h28);
         wr(IX_B, 8'h38);
         rdc(IX_B, 8'h38);
         `CHK(lsosc_enable, 1'b0)
         wr(IX_B, 8'h28);
      end
   endtask

   task t_detect;
      begin
         wr(IX_D, 8'h03);
         rdc(IX_D, 8'h03);
         xtal_stop_detect <= 1'b1;
         @(posedge hclk);
         rdc(IX_D, 8'h0F);
         wr(IX_D, 8'h01);
         rdc(IX_D, 8'h0D);
         wr(IX_D, 8'h04);
         rdc(IX_D, 8'h04);
         xtal_stop_detect <= 1'b0;
      end
   endtask

   initial begin
      errors = 0;
      compares = 0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
      xtal_stop_detect = 1'b0;
      periph_irq = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_div;
      t_osc;
      t_wait;
      t_stop;
      t_detect;
      end_of_test;
   end
endmodule // testbench
